//--- logic/pss_pkg.sv
/*
 * Constants shared by the pipelined sync memory port: register offsets,
 * status field positions, reset values and the burst mode type.
 * Assumes a 32-bit Avalon-MM register slave with byte addressing.
 */
package pss_pkg;
	localparam int PSS_ADDR_W = 19;
	localparam int PSS_DATA_W = 36;
	localparam int PSS_LANES = 4;
	localparam logic [3:0] PSS_OFS_CTRL = 4'h0;
	localparam logic [3:0] PSS_OFS_STATUS = 4'h4;
	localparam int PSS_CTRL_LINEAR = 0;
	localparam logic PSS_CTRL_LINEAR_RST = 1'b0;
	localparam int PSS_ST_SLEEP = 0;
	localparam int PSS_ST_BURST = 1;
	localparam int PSS_ST_CNT = 2;
	localparam int PSS_ST_DRIVE = 4;
	localparam logic [1:0] PSS_CNT_RST = 2'h0;
	localparam logic [1:0] PSS_CNT_STEP = 2'h1;
	localparam logic [31:0] PSS_RDATA_RST = 32'h0000_0000;
	typedef enum logic {
		PSS_IDLE = 1'b0,
		PSS_BURST = 1'b1
	} pss_mode_t;
endpackage : pss_pkg

//--- logic/pss_sram_port.sv
/*
 * Pipelined double-cycle-deselect synchronous memory port with its array.
 * Assumes the far side drives all synchronous pins from the same clk, and
 * that software sets the burst order over a 32-bit Avalon-MM slave.
 */
// Function
// - Every synchronous pin is captured into an input register each rising edge.
// - Address and chip enables load only on an edge with a strobe asserted.
// - Later burst addresses come from a two-bit counter stepped by burst advance.
// - Burst order is interleaved or linear, chosen by a software setting.
// - Writes use registered address, data and controls, then complete internally.
// - Unless all-lanes write is low, only lanes picked by lane selects, qualified by the lane qualifier, are written.
// - A low all-lanes write writes every lane regardless of lane selects.
// - Output drive stays on one extra cycle after a deselect.
// - Output enable and sleep request gate the driver asynchronously; sleep idles the port only after clock sampling.
// - A burst returns its first word two cycles after start, then one per cycle.
// - Two bank selects let several banks share one bus without wait states.
`timescale 1ns/1ps
module pss_sram_port #(
	parameter int ADDR_W = pss_pkg::PSS_ADDR_W,
	parameter int DATA_W = pss_pkg::PSS_DATA_W,
	parameter int LANES = pss_pkg::PSS_LANES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM register slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Synchronous memory bus
	input wire logic [ADDR_W-1:0] sram_addr,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic pipelined_chip_select_n,
	input wire logic bank_select_high,
	input wire logic bank_select_low_n,
	input wire logic [LANES-1:0] lane_write_select_n,
	input wire logic lane_write_qualifier_n,
	input wire logic all_lanes_write_n,
	// Asynchronous controls
	input wire logic output_enable_n,
	input wire logic sleep_request,
	// Data pins
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe
);
	import pss_pkg::*;

	localparam int LANE_W = DATA_W / LANES;
	localparam int DEPTH = 1 << ADDR_W;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] din;
		logic processor_addr_strobe_n_n;
		logic controller_addr_strobe_n_n;
		logic adv_n;
		logic ce1_n;
		logic ce2;
		logic ce3_n;
		logic [LANES-1:0] bw_n;
		logic bwe_n;
		logic gw_n;
		logic slp1;
		logic slp2;
		logic slp3;
		logic slp;
		pss_mode_t mode;
		logic [ADDR_W-1:0] base;
		logic [1:0] cnt;
		logic rd_v;
		logic out_en;
		logic drive;
		logic [DATA_W-1:0] out_data;
		logic linear;
		logic waitreq;
		logic [31:0] rdata;
	} pss_state_t;

	pss_state_t st_q;
	pss_state_t st_d;
	logic [DATA_W-1:0] mem_q [0:DEPTH-1];
	logic [DATA_W-1:0] rd_data_q;
	logic start;
	logic sel;
	logic acc_ok;
	logic wr_go;
	logic rd_go;
	logic [LANES-1:0] wr_mask;
	logic [ADDR_W-1:0] acc_addr;
	logic [31:0] status;

	// Low two address bits of the current beat for either burst order.
	function automatic logic [1:0] pss_burst_lsb(input logic [1:0] b, input logic [1:0] c,
		input logic lin);
		pss_burst_lsb = lin ? 2'(b + c) : (b ^ c);
	endfunction : pss_burst_lsb

	always_comb begin
		st_d = st_q;
		// All synchronous pins pass one register before any decision.
		st_d.addr = sram_addr;
		st_d.din = dq_in;
		st_d.processor_addr_strobe_n_n = processor_addr_strobe_n;
		st_d.controller_addr_strobe_n_n = controller_addr_strobe_n;
		st_d.adv_n = burst_advance_n;
		st_d.ce1_n = pipelined_chip_select_n;
		st_d.ce2 = bank_select_high;
		st_d.ce3_n = bank_select_low_n;
		st_d.bw_n = lane_write_select_n;
		st_d.bwe_n = lane_write_qualifier_n;
		st_d.gw_n = all_lanes_write_n;
		// The status copy of sleep is synchronised; the pin itself gates outputs directly.
		st_d.slp1 = sleep_request;
		st_d.slp2 = st_q.slp1;
		st_d.slp3 = st_q.slp2;
		if (st_q.slp2 == st_q.slp3) begin
			st_d.slp = st_q.slp3;
		end
		// The processor strobe is ignored while the pipelined select is high.
		start = ~st_q.slp & (~st_q.controller_addr_strobe_n_n | (~st_q.processor_addr_strobe_n_n & ~st_q.ce1_n));
		sel = ~st_q.ce1_n & st_q.ce2 & ~st_q.ce3_n;
		if (~st_q.gw_n) begin
			wr_mask = '1;
		end else if (~st_q.bwe_n) begin
			wr_mask = ~st_q.bw_n;
		end else begin
			wr_mask = '0;
		end
		if (start) begin
			st_d.base = st_q.addr;
			st_d.cnt = PSS_CNT_RST;
			st_d.mode = sel ? PSS_BURST : PSS_IDLE;
		end else if (st_q.slp) begin
			st_d.mode = PSS_IDLE;
		end else if (st_q.mode == PSS_BURST && ~st_q.adv_n) begin
			st_d.cnt = 2'(st_q.cnt + PSS_CNT_STEP);
		end
		acc_addr = {st_d.base[ADDR_W-1:2], pss_burst_lsb(st_d.base[1:0], st_d.cnt,
			st_q.linear)};
		acc_ok = start ? sel : (st_q.mode == PSS_BURST && ~st_q.slp);
		// A cycle started by the processor strobe is always a read.
		wr_go = acc_ok & ~(start & st_q.controller_addr_strobe_n_n) & (|wr_mask);
		rd_go = acc_ok & ~wr_go;
		st_d.rd_v = rd_go;
		st_d.out_en = st_q.rd_v;
		st_d.out_data = rd_data_q;
		// Drive follows the read pipe plus one trailing cycle, so a bank switch
		// never leaves the bus floating between two back-to-back reads.
		st_d.drive = st_q.rd_v | st_q.out_en;
		status = '0;
		status[PSS_ST_SLEEP] = st_q.slp;
		status[PSS_ST_BURST] = (st_q.mode == PSS_BURST);
		status[PSS_ST_CNT +: 2] = st_q.cnt;
		status[PSS_ST_DRIVE] = st_q.drive;
		if ((avs_read | avs_write) && st_q.waitreq) begin
			st_d.waitreq = 1'b0;
			if (avs_address == PSS_OFS_CTRL) begin
				st_d.rdata = '0;
				st_d.rdata[PSS_CTRL_LINEAR] = st_q.linear;
			end else if (avs_address == PSS_OFS_STATUS) begin
				st_d.rdata = status;
			end else begin
				st_d.rdata = PSS_RDATA_RST;
			end
		end else begin
			st_d.waitreq = 1'b1;
			if (avs_write && !st_q.waitreq && avs_address == PSS_OFS_CTRL
				&& avs_byteenable[0]) begin
				st_d.linear = avs_writedata[PSS_CTRL_LINEAR];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
			st_q.processor_addr_strobe_n_n <= 1'b1;
			st_q.controller_addr_strobe_n_n <= 1'b1;
			st_q.adv_n <= 1'b1;
			st_q.ce1_n <= 1'b1;
			st_q.ce3_n <= 1'b1;
			st_q.bw_n <= '1;
			st_q.bwe_n <= 1'b1;
			st_q.gw_n <= 1'b1;
			st_q.mode <= PSS_IDLE;
			st_q.cnt <= PSS_CNT_RST;
			st_q.linear <= PSS_CTRL_LINEAR_RST;
			st_q.waitreq <= 1'b1;
			st_q.rdata <= PSS_RDATA_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// The array has no reset; contents are undefined until written.
	always_ff @(posedge clk) begin
		for (int i = 0; i < LANES; i++) begin
			if (wr_go && wr_mask[i]) begin
				mem_q[acc_addr][i*LANE_W +: LANE_W] <= st_q.din[i*LANE_W +: LANE_W];
			end
		end
		rd_data_q <= mem_q[acc_addr];
	end

	assign avs_readdata = st_q.rdata;
	assign avs_waitrequest = st_q.waitreq;
	assign dq_out = st_q.out_data;
	// Output enable and sleep gate the driver without a clock, as the bus expects.
	assign dq_oe = st_q.drive & ~output_enable_n & ~sleep_request;

	default clocking pss_cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_pin_capture;
		!$past(rst) |-> st_q.adv_n == $past(burst_advance_n)
			&& st_q.gw_n == $past(all_lanes_write_n);
	endproperty
	a_pin_capture: assert property (p_pin_capture) else $error("pin capture lost");

	property p_base_on_strobe;
		!$past(rst) && st_q.base != $past(st_q.base) |-> $past(start);
	endproperty
	a_base_on_strobe: assert property (p_base_on_strobe) else $error("base moved");

	property p_count_step;
		!start && !st_q.slp && st_q.mode == PSS_BURST && !st_q.adv_n
			|=> st_q.cnt == 2'($past(st_q.cnt) + 2'h1);
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter missed");

	property p_interleave;
		acc_ok && !start && !st_q.linear |-> (acc_addr[1:0] ^ st_q.base[1:0]) == st_d.cnt;
	endproperty
	a_interleave: assert property (p_interleave) else $error("bad order");

	property p_full_write;
		acc_ok && !st_q.gw_n && !(start && st_q.controller_addr_strobe_n_n) |-> wr_go && wr_mask == '1;
	endproperty
	a_full_write: assert property (p_full_write) else $error("lanes missed");

	property p_no_qualifier;
		st_q.gw_n && st_q.bwe_n |-> !wr_go;
	endproperty
	a_no_qualifier: assert property (p_no_qualifier) else $error("unqualified write");

	property p_dcd_hold;
		$fell(st_q.out_en) |-> st_q.drive ##1 !st_q.drive || st_q.out_en;
	endproperty
	a_dcd_hold: assert property (p_dcd_hold) else $error("drive hold wrong");

	property p_async_gate;
		output_enable_n || sleep_request |-> !dq_oe;
	endproperty
	a_async_gate: assert property (p_async_gate) else $error("driver on");

	property p_read_latency;
		rd_go |=> st_q.rd_v ##1 st_q.out_en && st_q.drive && dq_out == $past(rd_data_q);
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read late");

	property p_bank_miss;
		start && !sel |-> !wr_go && !rd_go ##1 st_q.mode == PSS_IDLE;
	endproperty
	a_bank_miss: assert property (p_bank_miss) else $error("deselect touched");

	property p_ctrl_strobe;
		start && (st_q.ce1_n || !st_q.ce2) |-> !acc_ok;
	endproperty
	a_ctrl_strobe: assert property (p_ctrl_strobe) else $error("bank ignored");

	property p_addr_load;
		start |=> st_q.base == $past(st_q.addr) && st_q.cnt == PSS_CNT_RST;
	endproperty
	a_addr_load: assert property (p_addr_load) else $error("address not loaded");

	property p_count_hold;
		!start && st_q.adv_n |=> st_q.cnt == $past(st_q.cnt);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("counter moved");

	property p_write_here;
		start && sel && !st_q.controller_addr_strobe_n_n && !st_q.gw_n |-> wr_go && acc_addr == st_q.addr;
	endproperty
	a_write_here: assert property (p_write_here) else $error("write misplaced");

	property p_sleep_idle;
		st_q.slp |-> !acc_ok && !wr_go;
	endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("access while asleep");

	property p_ack_once;
		!st_q.waitreq |=> st_q.waitreq;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held too long");
endmodule : pss_sram_port

//--- bench/pss_bus_model.sv
/*
 * Bus master model that drives the memory pins of the port.
 * Assumes it shares clk with the port and that the bench calls its tasks.
 */
`timescale 1ns/1ps
module pss_bus_model (
	// Clock
	input wire logic clk,
	// Memory bus
	output logic [pss_pkg::PSS_ADDR_W-1:0] sram_addr,
	output logic processor_addr_strobe_n,
	output logic controller_addr_strobe_n,
	output logic burst_advance_n,
	output logic pipelined_chip_select_n,
	output logic bank_select_high,
	output logic bank_select_low_n,
	output logic [3:0] lane_write_select_n,
	output logic lane_write_qualifier_n,
	output logic all_lanes_write_n,
	// Data
	output logic [35:0] dq_in,
	input wire logic [35:0] dq_out,
	input wire logic dq_oe
);
	import pss_pkg::*;
	task automatic idle();
		processor_addr_strobe_n <= 1'b1;
		controller_addr_strobe_n <= 1'b1;
		burst_advance_n <= 1'b1;
		bank_select_high <= 1'b1;
		lane_write_select_n <= 4'hf;
		lane_write_qualifier_n <= 1'b1;
		all_lanes_write_n <= 1'b1;
	endtask : idle
	task automatic wr(input logic [18:0] a, input logic [3:0] sel_n, input logic gw_n,
		input logic bank, input logic [35:0] d);
		@(posedge clk);
		sram_addr <= a;
		controller_addr_strobe_n <= 1'b0;
		bank_select_high <= bank;
		lane_write_select_n <= sel_n;
		lane_write_qualifier_n <= 1'b0;
		all_lanes_write_n <= gw_n;
		dq_in <= d;
		@(posedge clk);
		idle();
		// Released data lines must not keep looking valid.
		dq_in <= ~d;
	endtask : wr
	task automatic rd(input logic [18:0] a, input logic p, output logic [36:0] q [4]);
		@(posedge clk);
		sram_addr <= a;
		if (p) begin
			processor_addr_strobe_n <= 1'b0;
		end else begin
			controller_addr_strobe_n <= 1'b0;
		end
		@(posedge clk);
		processor_addr_strobe_n <= 1'b1;
		controller_addr_strobe_n <= 1'b1;
		burst_advance_n <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			if (i == 1) begin
				burst_advance_n <= 1'b1;
			end
			#1 q[i] = {dq_oe, dq_out};
		end
	endtask : rd
	initial begin
		sram_addr <= '0;
		pipelined_chip_select_n <= 1'b0;
		bank_select_low_n <= 1'b0;
		dq_in <= '0;
		idle();
	end
endmodule : pss_bus_model

//--- bench/pss_sram_port_tb.sv
/*
 * Self-checking bench for the sync memory port.
 * Assumes the bus model drives the memory pins and this bench the rest.
 */
`timescale 1ns/1ps
module pss_sram_port_tb;
	import pss_pkg::*;
	typedef struct packed {
		logic [3:0] sel_n;
		logic gw_n;
		logic [35:0] exp;
	} pss_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, r;
	logic avs_waitrequest, dq_oe;
	logic [18:0] sram_addr;
	logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
	logic pipelined_chip_select_n, bank_select_high, bank_select_low_n;
	logic [3:0] lane_write_select_n;
	logic lane_write_qualifier_n, all_lanes_write_n;
	logic output_enable_n = 1'b0;
	logic sleep_request = 1'b0;
	logic [35:0] dq_in, dq_out;
	logic [36:0] q [4];
	int failures = 0;
	int cmp_count = 0;
	pss_row_t rows [5] = '{'{4'he, 1'b1, 36'h0_0000_01ff}, '{4'h5, 1'b1, 36'hf_f803_fe00},
		'{4'h0, 1'b1, 36'hf_ffff_ffff}, '{4'hf, 1'b1, 36'h0_0000_0000},
		'{4'hf, 1'b0, 36'hf_ffff_ffff}};
	pss_sram_port dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .sram_addr,
		.processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
		.pipelined_chip_select_n, .bank_select_high, .bank_select_low_n, .lane_write_select_n,
		.lane_write_qualifier_n, .all_lanes_write_n, .output_enable_n, .sleep_request, .dq_in,
		.dq_out, .dq_oe);
	pss_bus_model host (.clk, .sram_addr, .processor_addr_strobe_n, .controller_addr_strobe_n,
		.burst_advance_n, .pipelined_chip_select_n, .bank_select_high, .bank_select_low_n,
		.lane_write_select_n, .lane_write_qualifier_n, .all_lanes_write_n, .dq_in, .dq_out,
		.dq_oe);
	task automatic report_and_stop();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [36:0] got, input logic [36:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		// The request stands until an edge samples waitrequest low.
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			failures++;
			report_and_stop();
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : av
	initial forever #5 clk = ~clk;
	initial begin
		#50 chk(37'(avs_waitrequest), 37'h1);
		chk(37'(dq_oe), 37'h0);
		chk(37'(avs_readdata), 37'h0);
		repeat (7) @(posedge clk);
		rst <= 1'b0;
		av(1'b0, 4'h0, 32'h0000_0000, r);
		chk(37'(r), 37'h0);
		av(1'b0, 4'hc, 32'h0000_0000, r);
		chk(37'(r), 37'h0);
		// Every word that a burst below can reach is written first.
		for (int a = 4; a < 12; a++) host.wr(19'(a), 4'hf, 1'b0, 1'b1, 36'(a + 16));
		foreach (rows[i]) begin
			host.wr(19'h8, 4'hf, 1'b0, 1'b1, '0);
			host.wr(19'h8, rows[i].sel_n, rows[i].gw_n, 1'b1, 36'hf_ffff_ffff);
			host.rd(19'h8, 1'b0, q);
			chk(q[0], {1'b1, rows[i].exp});
		end
		for (int m = 0; m < 2; m++) begin
			// Base 5 tells the two orders apart on the second and fourth beats only.
			if (m == 1) av(1'b1, 4'h0, 32'h0000_0001, r);
			host.rd(19'h5, 1'(m == 0), q);
			for (int i = 0; i < 4; i++)
				chk(q[i], {1'b1, 36'(20 + (m ? (1 + i) % 4 : 1 ^ i))});
		end
		// The idling burst keeps the driver on, so the gates show alone.
		@(posedge clk);
		output_enable_n <= 1'b1;
		#1 chk(37'(dq_oe), 37'h0);
		@(posedge clk);
		output_enable_n <= 1'b0;
		sleep_request <= 1'b1;
		#1 chk(37'(dq_oe), 37'h0);
		// A one-cycle sleep pulse is too short for the filter to accept.
		@(posedge clk);
		sleep_request <= 1'b0;
		#1 chk(37'(dq_oe), 37'h1);
		host.wr(19'h5, 4'hf, 1'b0, 1'b0, '0);
		repeat (2) @(posedge clk);
		#1 chk(37'(dq_oe), 37'h1);
		@(posedge clk);
		#1 chk(37'(dq_oe), 37'h0);
		host.rd(19'h5, 1'b0, q);
		chk(q[0], {1'b1, 36'h0_0000_0015});
		// A held sleep request idles the port and freezes the beat counter.
		@(posedge clk);
		sleep_request <= 1'b1;
		repeat (8) @(posedge clk);
		av(1'b0, 4'h4, 32'h0000_0000, r);
		chk(37'(r), 37'((32'h1 << PSS_ST_SLEEP) | (32'h3 << PSS_ST_CNT)));
		chk(37'(dq_oe), 37'h0);
		@(posedge clk);
		sleep_request <= 1'b0;
		report_and_stop();
	end
endmodule : pss_sram_port_tb
